// [rtl/rff_defines.svh]
/*
  Offsets, field positions, reset values and size limits of the record FIFO engine.
  Assumes inclusion by bare name from every file that needs these constants.
*/
`ifndef RFF_DEFINES_SVH
`define RFF_DEFINES_SVH

// apb register byte offsets
`define RFF_OFF_CTRL 12'h000
`define RFF_OFF_SCAN 12'h004
`define RFF_OFF_FMT_CFG 12'h008
`define RFF_OFF_FMT_BASE 12'h00C
`define RFF_OFF_XFER 12'h010
`define RFF_OFF_STATUS 12'h014
`define RFF_OFF_INT_STAT 12'h018
`define RFF_OFF_INT_MASK 12'h01C
`define RFF_OFF_MEM_ADDR 12'h020
`define RFF_OFF_MEM_DATA 12'h024
`define RFF_OFF_FLAGS_LO 12'h028
`define RFF_OFF_FLAGS_HI 12'h02C

// control register fields
`define RFF_CTRL_FMT_BIT 0
`define RFF_CTRL_PUSH_BIT 1
`define RFF_CTRL_POP_BIT 2
`define RFF_CTRL_FILE_LSB 4

// interrupt status bits
`define RFF_INT_DONE 0
`define RFF_INT_FULL 1
`define RFF_INT_EMPTY 2
`define RFF_INT_RANGE 3
`define RFF_INT_PERR 4

// sizes and limits
`define RFF_NUM_FILES 10
`define RFF_MEM_AW 10
`define RFF_MEM_DW 16
`define RFF_NUM_FLAGS 64
`define RFF_FLAG_AW 6
`define RFF_STATUS_BASE_MAX 6'h2D
`define RFF_MIN_RECORDS 8'h02
`define RFF_MIN_SIZE 8'h01

// reset values
`define RFF_CTRL_RESET 8'h00
`define RFF_MASK_RESET 5'h00

`endif

// [rtl/rff_pkg.sv]
/*
  Types shared by the record FIFO engine and its memory and flag modules.
  Assumes rff_defines.svh sits on the include path.
*/
`include "rff_defines.svh"

package rff_pkg;

  typedef enum logic [3:0] {
    ST_IDLE, ST_NEXT, ST_FMT, ST_RD_WI, ST_RD_RI, ST_CHK, ST_CRD, ST_CWR, ST_WB
  } rff_state_t;

  // one entry of the file table
  typedef struct packed {
    logic formatted;
    logic [7:0] record_size;
    logic [7:0] record_count;
    logic [`RFF_MEM_AW-1:0] file_base;
    logic [`RFF_FLAG_AW-1:0] status_base;
  } rff_file_t;

  // one word-memory request
  typedef struct packed {
    logic we;
    logic [`RFF_MEM_AW-1:0] addr;
    logic [`RFF_MEM_DW-1:0] wdata;
  } rff_mem_req_t;

  // three status flags written at once
  typedef struct packed {
    logic we;
    logic [`RFF_FLAG_AW-1:0] base;
    logic [2:0] bits;
  } rff_flag_req_t;

endpackage : rff_pkg

// [rtl/rff_word_mem.sv]
/*
  Word memory holding file indices, records and source or destination words.
  Assumes one request per cycle; read data appear one clock after the address.
*/
`timescale 1ns/1ns
`include "rff_defines.svh"

module rff_word_mem (
  input wire logic pclk,
  input wire rff_pkg::rff_mem_req_t req,
  output logic [`RFF_MEM_DW-1:0] rdata_q
);
  import rff_pkg::*;

  logic [`RFF_MEM_DW-1:0] mem_q [0:(1<<`RFF_MEM_AW)-1];

  // no reset on the array, contents are undefined until written
  always_ff @(posedge pclk) begin
    if (req.we) begin
      mem_q[req.addr] <= req.wdata;
    end
    rdata_q <= mem_q[req.addr];
  end

endmodule : rff_word_mem

// [rtl/rff_flag_bank.sv]
/*
  Bank of single-bit flags; three consecutive flags are written per request.
  Assumes the base plus two stays inside the bank.
*/
`timescale 1ns/1ns
`include "rff_defines.svh"

module rff_flag_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire rff_pkg::rff_flag_req_t req,
  output logic [`RFF_NUM_FLAGS-1:0] flags_q
);
  import rff_pkg::*;

  // each flag compares its own index against the three-wide window
  for (genvar i = 0; i < `RFF_NUM_FLAGS; i++) begin : g_flag
    localparam logic [`RFF_FLAG_AW:0] IDX = (`RFF_FLAG_AW+1)'(i);
    logic [`RFF_FLAG_AW:0] off;
    assign off = IDX - {1'b0, req.base};
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flags_q[i] <= 1'b0;
      end else if (req.we && off < (`RFF_FLAG_AW+1)'(3)) begin
        flags_q[i] <= req.bits[off[1:0]];
      end
    end
  end

endmodule : rff_flag_bank

// [rtl/rff_engine.sv]
/*
  Record FIFO file engine: APB registers, file table, format/push/pop sequencer.
  Assumes a single 25 MHz pclk and an APB master on the same clock.
*/
`timescale 1ns/1ns
`include "rff_defines.svh"

// How it works
// - ten files, numbered zero to nine, each number one file.
// - a record is record_size consecutive words, one to 255.
// - a file holds record_count records, two to 255.
// - file region spans record_size times record_count plus two words.
// - word 0 write index, word 1 read index, records from base plus two.
// - three consecutive status flags start at status_base.
// - each enabled operation runs at most once per scan.
// - push copies a record in at write_index then bumps it.
// - write_index wraps to zero after the last record.
// - pop copies the record at read_index out then bumps it.
// - read_index wraps to zero after the last record.
// - records leave in the order pushed.
// - full when next write_index meets read_index; push then sets flag 0.
// - empty when indices equal; pop then does nothing, sets flag 1.
// - index beyond record_count minus one aborts and sets flag 2.
// - push or pop on an unformatted file raises program error.
module rff_engine (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic err_ind
);
  import rff_pkg::*;

  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [7:0] ctrl_q;
  logic [31:0] fmt_cfg_q;
  logic [`RFF_MEM_AW-1:0] fmt_base_q;
  logic [`RFF_MEM_AW-1:0] src_q;
  logic [`RFF_MEM_AW-1:0] dst_q;
  logic [`RFF_MEM_AW-1:0] mem_addr_q;
  logic [4:0] int_stat_q;
  logic [4:0] int_mask_q;
  logic [4:0] int_evt;
  logic [2:0] last_flags_q;
  rff_state_t state_q;
  rff_file_t files_q [0:`RFF_NUM_FILES-1];
  rff_file_t cur;
  logic [2:0] pend_q;
  logic is_push_q;
  logic [3:0] fnum_q;
  logic [7:0] wi_q;
  logic [7:0] ri_q;
  logic [7:0] k_q;
  logic [7:0] idx_nxt;
  logic [15:0] rec_off;
  logic [`RFF_MEM_AW-1:0] rec_addr;
  logic [`RFF_MEM_DW-1:0] mem_rdata;
  logic [`RFF_NUM_FLAGS-1:0] flags;
  rff_mem_req_t mreq;
  rff_flag_req_t freq_q;
  logic busy;
  logic acc_done;
  logic wr_done;
  logic scan_go;
  logic rng_bad;
  logic is_full;
  logic is_empty;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign err_ind = int_stat_q[`RFF_INT_PERR];

  assign busy = (state_q != ST_IDLE);
  assign acc_done = psel && penable && pready_q;
  assign wr_done = acc_done && pwrite && !pslverr_q;
  assign scan_go = wr_done && paddr == `RFF_OFF_SCAN && pwdata[0] && !busy;

  // one wait state on every access: answer prepared, then pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (paddr == `RFF_OFF_CTRL) begin
        prdata_q <= {24'h000000, ctrl_q};
      end else if (paddr == `RFF_OFF_SCAN) begin
        prdata_q <= 32'h0000_0000;
      end else if (paddr == `RFF_OFF_FMT_CFG) begin
        prdata_q <= fmt_cfg_q;
      end else if (paddr == `RFF_OFF_FMT_BASE) begin
        prdata_q <= {22'h000000, fmt_base_q};
      end else if (paddr == `RFF_OFF_XFER) begin
        prdata_q <= {6'h00, dst_q, 6'h00, src_q};
      end else if (paddr == `RFF_OFF_STATUS) begin
        prdata_q <= {27'h0000000, last_flags_q, int_stat_q[`RFF_INT_PERR], busy};
      end else if (paddr == `RFF_OFF_INT_STAT) begin
        prdata_q <= {27'h0000000, int_stat_q};
      end else if (paddr == `RFF_OFF_INT_MASK) begin
        prdata_q <= {27'h0000000, int_mask_q};
      end else if (paddr == `RFF_OFF_MEM_ADDR) begin
        prdata_q <= {22'h000000, mem_addr_q};
      end else if (paddr == `RFF_OFF_MEM_DATA) begin
        prdata_q <= {16'h0000, mem_rdata};
        pslverr_q <= busy; // memory belongs to the sequencer while busy
      end else if (paddr == `RFF_OFF_FLAGS_LO) begin
        prdata_q <= flags[31:0];
      end else if (paddr == `RFF_OFF_FLAGS_HI) begin
        prdata_q <= flags[63:32];
      end else begin
        pslverr_q <= 1'b1;
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // software-written configuration; writes land on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `RFF_CTRL_RESET;
      fmt_cfg_q <= 32'h0000_0000;
      fmt_base_q <= 10'h000;
      src_q <= 10'h000;
      dst_q <= 10'h000;
      int_mask_q <= `RFF_MASK_RESET;
    end else if (wr_done) begin
      if (paddr == `RFF_OFF_CTRL) begin
        ctrl_q <= pwdata[7:0];
      end else if (paddr == `RFF_OFF_FMT_CFG) begin
        fmt_cfg_q <= {10'h000, pwdata[21:0]};
      end else if (paddr == `RFF_OFF_FMT_BASE) begin
        fmt_base_q <= pwdata[9:0];
      end else if (paddr == `RFF_OFF_XFER) begin
        src_q <= pwdata[9:0];
        dst_q <= pwdata[25:16];
      end else if (paddr == `RFF_OFF_INT_MASK) begin
        int_mask_q <= pwdata[4:0];
      end
    end
  end

  // memory window pointer, steps after each data access that is not refused with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_q <= 10'h000;
    end else if (wr_done && paddr == `RFF_OFF_MEM_ADDR) begin
      mem_addr_q <= pwdata[9:0];
    end else if (acc_done && !pslverr_q && paddr == `RFF_OFF_MEM_DATA) begin
      mem_addr_q <= mem_addr_q + 10'h001;
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= 5'h00;
      irq_q <= 1'b0;
    end else begin
      if (wr_done && paddr == `RFF_OFF_INT_STAT) begin
        int_stat_q <= (int_stat_q & ~pwdata[4:0]) | int_evt;
      end else begin
        int_stat_q <= int_stat_q | int_evt;
      end
      irq_q <= |(int_stat_q & int_mask_q);
    end
  end

  // selected file and index arithmetic
  assign cur = files_q[fnum_q];
  assign idx_nxt = (is_push_q ? wi_q : ri_q) + 8'h01;
  assign rec_off = (is_push_q ? wi_q : ri_q) * cur.record_size;
  assign rec_addr = cur.file_base + 10'h002 + rec_off[9:0] + {2'b00, k_q};
  assign rng_bad = (wi_q >= cur.record_count) || (mem_rdata[7:0] >= cur.record_count)
                   || (mem_rdata[15:8] != 8'h00);
  assign is_empty = (wi_q == mem_rdata[7:0]);
  assign is_full = ((wi_q == cur.record_count - 8'h01) ? 8'h00 : wi_q + 8'h01)
                   == mem_rdata[7:0];

  // memory port: sequencer when busy, apb window otherwise
  always_comb begin
    mreq = '0;
    if (!busy) begin
      mreq.addr = mem_addr_q;
      mreq.we = wr_done && paddr == `RFF_OFF_MEM_DATA;
      mreq.wdata = pwdata[15:0];
    end else if (state_q == ST_RD_WI) begin
      mreq.addr = cur.file_base;
    end else if (state_q == ST_RD_RI) begin
      mreq.addr = cur.file_base + 10'h001;
    end else if (state_q == ST_CRD) begin
      mreq.addr = is_push_q ? src_q + {2'b00, k_q} : rec_addr;
    end else if (state_q == ST_CWR) begin
      mreq.we = 1'b1;
      mreq.addr = is_push_q ? rec_addr : dst_q + {2'b00, k_q};
      mreq.wdata = mem_rdata;
    end else if (state_q == ST_WB) begin
      mreq.we = 1'b1;
      mreq.addr = cur.file_base + (is_push_q ? 10'h000 : 10'h001);
      mreq.wdata = (idx_nxt == cur.record_count) ? 16'h0000 : {8'h00, idx_nxt};
    end
  end

  // operation sequencer: format, then push, then pop within one scan
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      pend_q <= 3'b000;
      is_push_q <= 1'b0;
      fnum_q <= 4'h0;
      wi_q <= 8'h00;
      ri_q <= 8'h00;
      k_q <= 8'h00;
      freq_q <= '0;
      last_flags_q <= 3'b000;
      int_evt <= 5'h00;
      for (int f = 0; f < `RFF_NUM_FILES; f++) begin
        files_q[f] <= '0;
      end
    end else begin
      freq_q.we <= 1'b0;
      int_evt <= 5'h00;
      case (state_q)
        ST_IDLE: begin
          if (scan_go) begin
            pend_q <= ctrl_q[2:0];
            fnum_q <= ctrl_q[`RFF_CTRL_FILE_LSB +: 4];
            state_q <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          k_q <= 8'h00;
          if (pend_q == 3'b000) begin
            int_evt[`RFF_INT_DONE] <= 1'b1;
            state_q <= ST_IDLE;
          end else if (fnum_q >= 4'(`RFF_NUM_FILES)) begin
            int_evt[`RFF_INT_PERR] <= 1'b1;
            pend_q <= 3'b000;
          end else if (pend_q[`RFF_CTRL_FMT_BIT]) begin
            pend_q[`RFF_CTRL_FMT_BIT] <= 1'b0;
            state_q <= ST_FMT;
          end else if (!cur.formatted) begin
            int_evt[`RFF_INT_PERR] <= 1'b1;
            pend_q <= 3'b000;
          end else begin
            is_push_q <= pend_q[`RFF_CTRL_PUSH_BIT];
            pend_q[pend_q[`RFF_CTRL_PUSH_BIT] ? 1 : 2] <= 1'b0;
            state_q <= ST_RD_WI;
          end
        end
        ST_FMT: begin
          // reserved system flags and bad sizes are refused
          if (fmt_cfg_q[7:0] < `RFF_MIN_SIZE || fmt_cfg_q[15:8] < `RFF_MIN_RECORDS
              || fmt_cfg_q[21:16] > `RFF_STATUS_BASE_MAX) begin
            int_evt[`RFF_INT_PERR] <= 1'b1;
          end else begin
            files_q[fnum_q] <= {1'b1, fmt_cfg_q[7:0], fmt_cfg_q[15:8], fmt_base_q,
                                fmt_cfg_q[21:16]};
          end
          state_q <= ST_NEXT;
        end
        ST_RD_WI: begin
          state_q <= ST_RD_RI;
        end
        ST_RD_RI: begin
          wi_q <= mem_rdata[7:0];
          state_q <= (mem_rdata[15:8] != 8'h00) ? ST_CHK : ST_CHK;
          if (mem_rdata[15:8] != 8'h00) begin
            wi_q <= 8'hFF; // out of any legal range
          end
        end
        ST_CHK: begin
          ri_q <= mem_rdata[7:0];
          freq_q.we <= 1'b1;
          freq_q.base <= cur.status_base;
          freq_q.bits <= {rng_bad, !is_push_q && is_empty && !rng_bad,
                          is_push_q && is_full && !rng_bad};
          last_flags_q <= {rng_bad, !is_push_q && is_empty && !rng_bad,
                           is_push_q && is_full && !rng_bad};
          if (rng_bad) begin
            int_evt[`RFF_INT_RANGE] <= 1'b1;
            state_q <= ST_NEXT;
          end else if (is_push_q && is_full) begin
            int_evt[`RFF_INT_FULL] <= 1'b1;
            state_q <= ST_NEXT;
          end else if (!is_push_q && is_empty) begin
            int_evt[`RFF_INT_EMPTY] <= 1'b1;
            state_q <= ST_NEXT;
          end else begin
            state_q <= ST_CRD;
          end
        end
        ST_CRD: begin
          state_q <= ST_CWR;
        end
        ST_CWR: begin
          k_q <= k_q + 8'h01;
          state_q <= (k_q + 8'h01 == cur.record_size) ? ST_WB : ST_CRD;
        end
        ST_WB: begin
          state_q <= ST_NEXT;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  rff_word_mem u_mem (
    .pclk(pclk),
    .req(mreq),
    .rdata_q(mem_rdata)
  );

  rff_flag_bank u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .req(freq_q),
    .flags_q(flags)
  );

endmodule : rff_engine

// [testbench/rff_engine_checker.sv]
/*
  Port assertions for rff_engine: answer timing, error replies, error and interrupt outputs.
  Assumes it is bound onto rff_engine, with one pclk domain and presetn async active low.
*/
`timescale 1ns/1ns
`include "rff_defines.svh"
module rff_engine_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic err_ind
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic fin;
  // access waiting for its answer, and a write taking effect
  assign acc = psel && penable && !pready;
  assign fin = psel && penable && pready && pwrite;
  chk_ready_after_acc: assert property (acc |=> pready)
    else $error("pready missing after access");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property (pready |-> $past(acc))
    else $error("pready without access");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_unmapped_err: assert property (acc && paddr > `RFF_OFF_FLAGS_HI |=> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (acc && paddr < `RFF_OFF_MEM_DATA && paddr[1:0] == 2'b00
    |=> !pslverr)
    else $error("mapped access refused");
  chk_perr_clear: assert property (fin && paddr == `RFF_OFF_INT_STAT && pwdata[4]
    |-> ##[1:2] !err_ind)
    else $error("err_ind not cleared");
  chk_perr_hold: assert property ($fell(err_ind) |-> $past(fin && paddr == `RFF_OFF_INT_STAT)
    || $past(fin && paddr == `RFF_OFF_INT_STAT, 2))
    else $error("err_ind fell without clear");
  // masking everything must silence irq after its one-cycle lag
  chk_irq_masked: assert property (fin && paddr == `RFF_OFF_INT_MASK && pwdata[4:0] == 5'h00
    |-> ##2 !irq)
    else $error("irq high while masked");
endmodule : rff_engine_checker

bind rff_engine rff_engine_checker i_rff_engine_checker (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .err_ind);

// [testbench/rff_ctl_model.sv]
/*
  Controller model: APB transfers and single scans of format, push and pop.
  Assumes callers run in step with pclk and a bench watchdog bounds every wait.
*/
`timescale 1ns/1ns
`include "rff_defines.svh"
module rff_ctl_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] q;
  logic e;
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // request held until pready is sampled, one idle edge before each setup
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // one scan pulse only, so each enabled op runs at most once
  task automatic scan(input logic [31:0] ctrl);
    xfer(1'b1, `RFF_OFF_CTRL, ctrl);
    xfer(1'b1, `RFF_OFF_SCAN, 32'h1);
    xfer(1'b0, `RFF_OFF_STATUS, 32'h0);
    repeat (40) if (q[0] === 1'b1) xfer(1'b0, `RFF_OFF_STATUS, 32'h0);
  endtask : scan
endmodule : rff_ctl_model

// [testbench/rff_engine_tb_top.sv]
/*
  Self-checking bench for rff_engine: format, push, pop, ring wrap, flags, errors, irq.
  Assumes rff_ctl_model drives the APB side and the checker is bound to the engine.
*/
`timescale 1ns/1ns
`include "rff_defines.svh"
module rff_engine_tb_top;
  logic pclk;
  logic presetn;
  // bus nets are driven by the controller model and the engine, never by this module
  wire logic psel;
  wire logic penable;
  wire logic pwrite;
  wire logic pready;
  wire logic pslverr;
  wire logic irq;
  wire logic err_ind;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata;
  wire logic [31:0] prdata;
  int n_fail;
  int checked;
  rff_engine i_rff_engine (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .err_ind(err_ind)
  );
  rff_ctl_model i_rff_ctl_model (
    .pclk(pclk),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );
  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_rff_ctl_model.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x,
    input string nm);
    i_rff_ctl_model.xfer(1'b0, a, 32'h0);
    cmp(nm, x, i_rff_ctl_model.q & m);
  endtask : rd
  // one memory word through the auto-incrementing window
  task automatic mr(input logic [9:0] a, input logic [31:0] x, input string nm);
    wr(`RFF_OFF_MEM_ADDR, {22'h0, a});
    rd(`RFF_OFF_MEM_DATA, 32'hFFFF, x, nm);
  endtask : mr
  task automatic push(input int r);
    wr(`RFF_OFF_MEM_ADDR, 32'h010);
    for (int w = 0; w < 3; w++) wr(`RFF_OFF_MEM_DATA, 32'h5000 + r * 16 + w);
    i_rff_ctl_model.scan(32'h22);
  endtask : push
  task automatic pop(input int r);
    i_rff_ctl_model.scan(32'h24);
    wr(`RFF_OFF_MEM_ADDR, 32'h030);
    for (int w = 0; w < 3; w++) rd(`RFF_OFF_MEM_DATA, 32'hFFFF, 32'h5000 + r * 16 + w, "pop");
  endtask : pop
  // flags of file 2 sit at bank bits 12:10
  task automatic flags(input logic [31:0] x);
    rd(`RFF_OFF_FLAGS_LO, 32'h1C00, x, "flags");
  endtask : flags
  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wr(`RFF_OFF_INT_MASK, 32'h1F);
    i_rff_ctl_model.scan(32'h52);
    rd(`RFF_OFF_STATUS, 32'h2, 32'h2, "perr");
    cmp("err_ind", 32'h1, {31'h0, err_ind});
    wr(`RFF_OFF_INT_STAT, 32'h1F);
    // the clear lands on the edge the write completes; look one edge later
    @(posedge pclk);
    cmp("err_ind", 32'h0, {31'h0, err_ind});
    // file 2: 3 words a record, 4 records, base 100, flags from 10
    wr(`RFF_OFF_FMT_CFG, 32'h000A0403);
    wr(`RFF_OFF_FMT_BASE, 32'h064);
    wr(`RFF_OFF_XFER, 32'h00300010);
    i_rff_ctl_model.scan(32'h21);
    wr(`RFF_OFF_MEM_ADDR, 32'h064);
    wr(`RFF_OFF_MEM_DATA, 32'h0);
    wr(`RFF_OFF_MEM_DATA, 32'h0);
    for (int r = 0; r < 4; r++) push(r);
    flags(32'h0400);
    mr(10'h064, 32'h3, "write index");
    mr(10'h06D, 32'h5021, "record 2 word 1");
    for (int r = 0; r < 3; r++) pop(r);
    flags(32'h0000);
    mr(10'h065, 32'h3, "read index");
    i_rff_ctl_model.scan(32'h24);
    flags(32'h0800);
    push(7);
    mr(10'h06F, 32'h5070, "last record");
    mr(10'h064, 32'h0, "write wrap");
    pop(7);
    mr(10'h065, 32'h0, "read wrap");
    wr(`RFF_OFF_MEM_ADDR, 32'h064);
    wr(`RFF_OFF_MEM_DATA, 32'h4);
    i_rff_ctl_model.scan(32'h22);
    flags(32'h1000);
    mr(10'h064, 32'h4, "index kept");
    cmp("irq", 32'h1, {31'h0, irq});
    wr(`RFF_OFF_INT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    cmp("irq", 32'h0, {31'h0, irq});
    rd(12'h100, 32'h0, 32'h0, "unmapped");
    cmp("pslverr", 32'h1, {31'h0, i_rff_ctl_model.e});
    i_rff_ctl_model.scan(32'hA2);
    cmp("file 10", 32'h1, {31'h0, err_ind});
    wr(`RFF_OFF_INT_STAT, 32'h1F);
    tally_and_finish;
  end
  // hang guard, far beyond the several hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    tally_and_finish;
  end
endmodule : rff_engine_tb_top
